// ==== core/rbt_defs.vh ====
// Constants shared by the registered bus transceiver core.
// Assumes inclusion by bare name from the core/ folder.
`ifndef RBT_DEFS_VH
`define RBT_DEFS_VH

// ****************************************
// Widths and depths
// ****************************************
`define RBT_DATA_WIDTH 18
`define RBT_BUF_DEPTH 2
`define RBT_PTR_WIDTH 1
`define RBT_CNT_WIDTH 2
`define RBT_CNT_FULL 2'h2

// ****************************************
// Reset values
// ****************************************
`define RBT_STORE_RST 18'h00000
`define RBT_CLK_PREV_RST 1'h0
`define RBT_OE_RST 1'h0

`endif

// ==== core/rbt_transceiver.v ====
// Registered 18-bit bus transceiver between an A bus and a B bus, one path per direction.
// Assumes every input is synchronous to sys_clk. The capture clocks are sampled as ordinary inputs.
// The surrounding logic resolves the pin wires from the output enables.
`timescale 1ns/1ps
`include "rbt_defs.vh"

// ****************************************
// One direction: storage, edge detect, buffer
// ****************************************
module rbt_path #(
	parameter WIDTH = `RBT_DATA_WIDTH
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Control
	input wire latch_enable,
	input wire capture_clock,
	input wire output_enable,
	// Data in from the source bus
	input wire [WIDTH-1:0] data_in,
	// Drive toward the destination bus
	output wire [WIDTH-1:0] data_out,
	output wire data_out_en,
	// Stream of captured words
	output wire word_valid,
	input wire word_ready,
	output wire [WIDTH-1:0] word_data,
	output wire capture_ready
);
	reg [WIDTH-1:0] store_reg;
	reg [WIDTH-1:0] store_next;
	reg clk_prev_reg;
	reg oe_reg;
	reg [WIDTH-1:0] buf_reg [0:`RBT_BUF_DEPTH-1];
	reg [`RBT_PTR_WIDTH-1:0] wr_ptr_reg;
	reg [`RBT_PTR_WIDTH-1:0] rd_ptr_reg;
	reg [`RBT_CNT_WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] out_reg;
	wire fall;
	wire push;
	wire pop;
	wire full;
	wire empty;

	assign fall = clk_prev_reg & ~capture_clock;
	assign full = (count_reg == `RBT_CNT_FULL);
	assign empty = (count_reg == {`RBT_CNT_WIDTH{1'b0}});
	assign push = fall & ~latch_enable & ~full;
	assign pop = ~empty & word_ready;

	// Storage selection
	always @* begin
		store_next = store_reg;
		if (latch_enable) begin
			store_next = data_in;
		end else if (fall) begin
			store_next = data_in;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			store_reg <= `RBT_STORE_RST;
			clk_prev_reg <= `RBT_CLK_PREV_RST;
			oe_reg <= `RBT_OE_RST;
		end else begin
			store_reg <= store_next;
			clk_prev_reg <= capture_clock;
			oe_reg <= output_enable;
		end
	end

	// ****************************************
	// Two-entry buffer of clocked captures
	// ****************************************
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_ptr_reg <= {`RBT_PTR_WIDTH{1'b0}};
			rd_ptr_reg <= {`RBT_PTR_WIDTH{1'b0}};
			count_reg <= {`RBT_CNT_WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (push) begin
			buf_reg[wr_ptr_reg] <= data_in;
		end
	end

	// Head word picked straight from the buffer flops
	always @* begin
		out_reg = buf_reg[rd_ptr_reg];
	end

	assign data_out = store_reg;
	assign data_out_en = oe_reg;
	assign word_valid = ~empty;
	assign word_data = out_reg;
	assign capture_ready = ~full;
endmodule // rbt_path

// ****************************************
// Top: both directions on the shared pins
// ****************************************
module rbt_transceiver #(
	parameter WIDTH = `RBT_DATA_WIDTH
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// A-to-B control
	input wire a_to_b_output_enable,
	input wire a_to_b_latch_enable,
	input wire a_to_b_capture_clock,
	// B-to-A control
	input wire b_to_a_output_enable_n,
	input wire b_to_a_latch_enable,
	input wire b_to_a_capture_clock,
	// A pins
	input wire [WIDTH-1:0] a_in,
	output wire [WIDTH-1:0] a_out,
	output wire a_oe,
	// B pins
	input wire [WIDTH-1:0] b_in,
	output wire [WIDTH-1:0] b_out,
	output wire b_oe,
	// A-to-B capture stream
	output wire ab_word_valid,
	input wire ab_word_ready,
	output wire [WIDTH-1:0] ab_word_data,
	output wire ab_capture_ready,
	// B-to-A capture stream
	output wire ba_word_valid,
	input wire ba_word_ready,
	output wire [WIDTH-1:0] ba_word_data,
	output wire ba_capture_ready
);
	// A-to-B: A pins are inputs, B pins are outputs
	rbt_path #(.WIDTH(WIDTH)) u_a_to_b (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.latch_enable(a_to_b_latch_enable),
		.capture_clock(a_to_b_capture_clock),
		.output_enable(a_to_b_output_enable),
		.data_in(a_in),
		.data_out(b_out),
		.data_out_en(b_oe),
		.word_valid(ab_word_valid),
		.word_ready(ab_word_ready),
		.word_data(ab_word_data),
		.capture_ready(ab_capture_ready)
	);

	// B-to-A mirror with inverted output enable
	rbt_path #(.WIDTH(WIDTH)) u_b_to_a (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.latch_enable(b_to_a_latch_enable),
		.capture_clock(b_to_a_capture_clock),
		.output_enable(~b_to_a_output_enable_n),
		.data_in(b_in),
		.data_out(a_out),
		.data_out_en(a_oe),
		.word_valid(ba_word_valid),
		.word_ready(ba_word_ready),
		.word_data(ba_word_data),
		.capture_ready(ba_capture_ready)
	);
endmodule // rbt_transceiver

// ==== verification/rbt_transceiver_properties.sv ====
// Port checker for the transceiver, bound to its top
// Assumes one sys_clk domain
`timescale 1ns/1ps
module rbt_props #(parameter WIDTH = 18) (
	input wire sys_clk, reset_n, a_to_b_output_enable, a_to_b_latch_enable, a_to_b_capture_clock,
	input wire b_to_a_output_enable_n, b_to_a_latch_enable, b_to_a_capture_clock, a_oe, b_oe,
	input wire ab_word_valid, ab_word_ready, ab_capture_ready,
	input wire [WIDTH-1:0] a_in, b_in, a_out, b_out, ab_word_data
);
// ****
// Properties
// ****
default clocking @(posedge sys_clk); endclocking
default disable iff (!reset_n);
sequence ab_fall; !a_to_b_latch_enable && $past(a_to_b_capture_clock) && !a_to_b_capture_clock; endsequence
sequence ba_fall; !b_to_a_latch_enable && $past(b_to_a_capture_clock) && !b_to_a_capture_clock; endsequence
chk_ab_pass: assert property (
	a_to_b_latch_enable |=> b_out == $past(a_in)) else $error("B missed A");
chk_ab_take: assert property (
	ab_fall |=> b_out == $past(a_in)) else $error("B missed capture");
chk_ab_hold: assert property (
	!a_to_b_latch_enable && !($past(a_to_b_capture_clock) && !a_to_b_capture_clock) |=> $stable(b_out))
	else $error("B moved");
chk_b_drive: assert property (
	1'b1 |=> b_oe == $past(a_to_b_output_enable)) else $error("B enable wrong");
chk_ba_pass: assert property (
	b_to_a_latch_enable |=> a_out == $past(b_in)) else $error("A missed B");
chk_ba_take: assert property (
	ba_fall |=> a_out == $past(b_in)) else $error("A missed capture");
chk_a_drive: assert property (
	1'b1 |=> a_oe == !$past(b_to_a_output_enable_n)) else $error("A enable wrong");
chk_ab_push: assert property (
	ab_fall ##0 (ab_capture_ready && !ab_word_valid) |=> ab_word_valid && ab_word_data == $past(a_in))
	else $error("word not queued");
chk_ab_stall: assert property (
	ab_word_valid && !ab_word_ready |=> ab_word_valid && $stable(ab_word_data)) else $error("word lost");
endmodule // rbt_props
bind rbt_transceiver rbt_props #(.WIDTH(WIDTH)) i_rbt_props(.*);

// ==== verification/rbt_partner.sv ====
// Far-side logic on both buses
// Assumes the device enables are high while it drives
`timescale 1ns/1ps
module rbt_partner (
	input wire [17:0] a_out, b_out, pa, pb,
	input wire a_oe, b_oe,
	output wire [17:0] a_in, b_in
);
// Far side lets go of a bus the device drives
assign a_in = a_oe ? a_out : pa;
assign b_in = b_oe ? b_out : pb;
endmodule // rbt_partner

// ==== verification/rbt_transceiver_bench.sv ====
// Random traffic both ways against a reference model
// Assumes rbt_partner resolves the shared pins
`timescale 1ns/1ps
module rbt_transceiver_bench;
logic sys_clk = 0, reset_n = 0, a_oe, b_oe, moe[2], pck[2];
logic [1:0] le = 0, ck = 0, oe = 0, rdy = 0, qn[2];
wire [1:0] vld, crdy;
wire [17:0] wd0, wd1;
logic [17:0] pa = 0, pb = 0, a_in, b_in, a_out, b_out, st[2], qd[2][2];
int bad_count = 0, n_checks = 0, seed = 7738, r, t, i, d;
initial forever #20 sys_clk = ~sys_clk;
rbt_transceiver i_rbt_transceiver(.sys_clk, .reset_n, .a_to_b_output_enable(oe[0]), .a_to_b_latch_enable(le[0]),
	.a_to_b_capture_clock(ck[0]), .b_to_a_output_enable_n(!oe[1]), .b_to_a_latch_enable(le[1]),
	.b_to_a_capture_clock(ck[1]), .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe, .ab_word_valid(vld[0]),
	.ab_word_ready(rdy[0]), .ab_word_data(wd0), .ab_capture_ready(crdy[0]), .ba_word_valid(vld[1]),
	.ba_word_ready(rdy[1]), .ba_word_data(wd1), .ba_capture_ready(crdy[1]));
rbt_partner i_rbt_partner(.a_out, .b_out, .pa, .pb, .a_oe, .b_oe, .a_in, .b_in);
// ****
// Reference model
// ****
always @(posedge sys_clk) begin : model
	logic [17:0] src[2];
	logic f;
	src[0] = moe[1] ? st[1] : pa;
	src[1] = moe[0] ? st[0] : pb;
	for (int k = 0; k < 2; k++) begin
		f = !le[k] && pck[k] && !ck[k];
		if (!reset_n) begin
			st[k] = 0; moe[k] = 0; qn[k] = 0; f = 0;
		end
		if (qn[k] != 0 && rdy[k]) begin
			qd[k][0] = qd[k][1];
			qn[k]--;
			if (f && qn[k] == 1) f = 0;
		end
		if (f && qn[k] < 2) begin
			qd[k][qn[k]] = src[k];
			qn[k] = qn[k] + 1;
		end
		if (reset_n && (le[k] || !le[k] && pck[k] && !ck[k])) st[k] = src[k];
		pck[k] = reset_n && ck[k];
		if (reset_n) moe[k] = oe[k];
	end
end
task cmp(input logic [17:0] g, e);
	n_checks++;
	if (g !== e) begin
		bad_count++;
		$display("wrong value at %0t: got %h expected %h", $time, g, e);
	end
endtask
task step(input int ple, prdy);
	@(negedge sys_clk);
	cmp(b_out, st[0]);
	cmp(b_oe, moe[0]);
	cmp(a_out, st[1]);
	cmp(a_oe, moe[1]);
	for (d = 0; d < 2; d++) begin
		cmp(vld[d], qn[d] != 0);
		cmp(crdy[d], qn[d] != 2);
		if (qn[d] != 0) cmp(d ? wd1 : wd0, qd[d][0]);
		r = $random(seed);
		if (!(le[d] && ck[d])) le[d] = r[2:0] < ple;
		ck[d] = r[3] && reset_n;
		oe[d] = r[4];
		rdy[d] = r[7:5] < prdy;
	end
	r = $random(seed);
	pa = r[17:0];
	r = $random(seed);
	pb = r[17:0];
endtask
task finish_test;
	$display("checks %0d mismatches %0d", n_checks, bad_count);
	if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
initial begin
	#200000;
	bad_count++;
	finish_test;
end
initial begin
	repeat (3) @(negedge sys_clk);
	reset_n = 1;
	for (t = 0; t < 4; t++) begin
		for (i = 0; i < 500; i++) begin
			if (t == 3) reset_n = i % 100 > 2;
			step(t == 0 ? 8 : t == 1 ? 0 : 3, t == 1 ? 1 : 4);
		end
		$display("test %0d done", t);
	end
	finish_test;
end
endmodule // rbt_transceiver_bench
